// >>> inc/vr_startup_consts.svh
// Named constants for the voltage-regulator start-up and strap logic.
`ifndef VR_STARTUP_CONSTS_SVH
`define VR_STARTUP_CONSTS_SVH
`define CLK_PERIOD_NS        32'd10
`define START_DELAY_NS       32'd500000
`define START_DELAY_CYC      (`START_DELAY_NS / `CLK_PERIOD_NS)
`define STEP_MV_X1000        32'd6250
`define UP_SLEW_UV_PER_US    32'd12000
`define STEP_TIME_NS         ((`STEP_MV_X1000 * 32'd1000) / `UP_SLEW_UV_PER_US)
`define STEP_CYC             (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define DOWN_SLEW_DIV        32'd3
`define VID_1P10             8'h48
`define VID_1P00             8'h58
`define VID_0P90             8'h68
`define VID_0P80             8'h78
`define VID_1P55             8'h00
`define VID_1P50             8'h08
`define VID_1P35             8'h20
`define VID_OFF              8'hF8
`define ADDR_A               8'h88
`define ADDR_B               8'h8A
`define TON_SCALE            32'd100
`endif

// >>> inc/vr_startup_pkg.sv
// Types shared by the start-up and strap logic.
package vr_startup_pkg;
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_DELAY = 2'b01,
    ST_RAMP  = 2'b11,
    ST_GOOD  = 2'b10
  } seq_state_e;
  typedef enum logic [1:0] {
    MODE_FULL_CCM = 2'b00,
    MODE_ONE_CCM  = 2'b01,
    MODE_ONE_PSM  = 2'b10
  } rail_mode_e;
endpackage

// >>> rtl/vr_startup_and_phase_config.sv
// Start-up sequencer, strap capture and phase configuration for a two-rail regulator controller.
// Overview of operation
// - Wait for enable only when logic, io-reference and input supplies are all ready.
// - Enable low turns all outputs off and clears every latched fault.
// - Only logic-supply reset or enable toggle clears faults, not other supply dropouts.
// - Any ready indication or enable dropping shuts both rails down immediately.
// - After enable, wait a fixed delay below one millisecond before ramping.
// - Step the ramp toward boot voltage at the configured upward slew rate.
// - Assert rail power-good only when enabled rails reach boot voltage without fault.
// - At reset, bus clock and data pins pick boot voltage 1.1/1.0/0.9/0.8 V.
// - Strap setting picks auxiliary boot 1.55, 1.5, 1.35 V or bus-pin code.
// - Strap setting also picks management address 0x88 or 0x8A.
// - Sample every phase negative sense input at reset to count phases.
// - Core phases 2..4 sensed high are disabled; phases 4,3,2 give 3,2,1 phases.
// - Auxiliary phase 2 high gives one phase; phase 1 high gives zero.
// - Auxiliary total sense high selects zero-phase, disabling the auxiliary rail.
// - Smallest configuration is one core phase with auxiliary rail disabled.
// - Active-low hints pick full-phase continuous, one-phase continuous or one-phase saving.
// - Enabled phase drives carry the pulse signal; disabled phases stay undriven.
// - Default upward slew 12 mV/us; no downward ramp, shutdown sets both targets straight to the off code.
`include "vr_startup_consts.svh"
module vr_startup_and_phase_config (
  input  wire logic       clock,                    // 100 MHz clock
  input  wire logic       srst,                     // Logic-supply power-on reset
  input  wire logic       io_reference_supply,      // Io-reference ready (async)
  input  wire logic       input_voltage_sense,      // Input-voltage ready (async)
  input  wire logic       chip_enable,              // Chip enable (async)
  input  wire logic       vid_bus_clock,            // Strap: bus clock pin level
  input  wire logic       vid_bus_data,             // Strap: bus data pin level
  input  wire logic [1:0] strap_setting_input,      // Decoded strap: [1:0] aux boot
  input  wire logic       strap_addr_sel,           // Decoded strap: address select
  input  wire logic [3:0] phase_sense_negative,     // Core phase 1..4 negative sense levels
  input  wire logic [1:0] aux_phase_sense_negative, // Aux phase 1..2 negative sense levels
  input  wire logic       aux_total_sense_negative, // Aux total negative sense level
  input  wire logic       low_power_hint0_n,        // Power hint 0, active low
  input  wire logic       low_power_hint1_n,        // Power hint 1, active low
  input  wire logic [3:0] core_pulse_in,            // Pulse from on-time engine, core
  input  wire logic [1:0] aux_pulse_in,             // Pulse from on-time engine, aux
  input  wire logic       fault_event,              // Protection trip, pulse or level
  output logic [3:0]      core_phase_drive,         // Core phase drives 1..4
  output logic [3:0]      core_drive_en,            // Core phase drive enables
  output logic [1:0]      aux_phase_drive,          // Aux phase drives 1..2
  output logic [1:0]      aux_drive_en,             // Aux phase drive enables
  output logic [7:0]      core_target_vid,          // Core ramp target code
  output logic [7:0]      aux_target_vid,           // Aux ramp target code
  output logic [7:0]      mgmt_address,             // Management bus address
  output logic            rail_power_good,          // Rail power-good
  output logic            fault_latched,            // Latched fault state
  output logic [1:0]      core_mode,                // Core operating mode
  output logic [1:0]      aux_mode                  // Aux operating mode
);
  logic [2:0] en_sync_reg;
  logic [2:0] io_sync_reg;
  logic [2:0] vin_sync_reg;
  logic       en_reg;
  logic       io_reg;
  logic       vin_reg;
  logic       strap_done_reg;
  logic [7:0] core_boot_reg;
  logic [7:0] aux_boot_reg;
  logic [3:0] core_ph_en_reg;
  logic [1:0] aux_ph_en_reg;
  logic       strap_bad_reg;
  vr_startup_pkg::seq_state_e state_reg;
  vr_startup_pkg::seq_state_e state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [7:0]  core_vid_next;
  logic [7:0]  aux_vid_next;

  // Three-stage synchronisers; a level is accepted when stages two and three agree.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      en_sync_reg  <= 3'h0;
      io_sync_reg  <= 3'h0;
      vin_sync_reg <= 3'h0;
      en_reg       <= 1'b0;
      io_reg       <= 1'b0;
      vin_reg      <= 1'b0;
    end
    else
    begin
      en_sync_reg  <= {en_sync_reg[1:0], chip_enable};
      io_sync_reg  <= {io_sync_reg[1:0], io_reference_supply};
      vin_sync_reg <= {vin_sync_reg[1:0], input_voltage_sense};
      if (en_sync_reg[2] == en_sync_reg[1])
        en_reg <= en_sync_reg[2];
      if (io_sync_reg[2] == io_sync_reg[1])
        io_reg <= io_sync_reg[2];
      if (vin_sync_reg[2] == vin_sync_reg[1])
        vin_reg <= vin_sync_reg[2];
    end
  end

  wire supplies_ok = io_reg & vin_reg;
  wire run_ok      = supplies_ok & en_reg & strap_done_reg;

  // Strap decode; straps are static board levels so no synchroniser is used.
  wire [7:0] bus_boot = (vid_bus_clock == 1'b0) ?
                        ((vid_bus_data == 1'b0) ? `VID_1P10 : `VID_1P00) :
                        ((vid_bus_data == 1'b0) ? `VID_0P90 : `VID_0P80);
  wire [7:0] aux_boot_sel = (strap_setting_input == 2'h0) ? `VID_1P55 :
                            (strap_setting_input == 2'h1) ? `VID_1P50 :
                            (strap_setting_input == 2'h2) ? `VID_1P35 : bus_boot;
  wire [3:0] core_en_dec = {~phase_sense_negative[3:1], 1'b1};
  wire       aux_off     = aux_total_sense_negative | aux_phase_sense_negative[0];
  wire [1:0] aux_en_dec  = aux_off ? 2'h0 : {~aux_phase_sense_negative[1], 1'b1};
  // Only contiguous core disables are supported; a gap is a strapping fault.
  wire core_gap = (phase_sense_negative[2] & ~phase_sense_negative[3]) |
                  (phase_sense_negative[1] & ~phase_sense_negative[2]) |
                  phase_sense_negative[0];
  wire aux_gap  = aux_phase_sense_negative[0] & ~aux_phase_sense_negative[1] & ~aux_total_sense_negative;

  // Captured once on the first clock after reset release and then frozen.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      strap_done_reg <= 1'b0;
      core_boot_reg  <= `VID_OFF;
      aux_boot_reg   <= `VID_OFF;
      mgmt_address   <= `ADDR_A;
      core_ph_en_reg <= 4'h0;
      aux_ph_en_reg  <= 2'h0;
      strap_bad_reg  <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      core_boot_reg  <= bus_boot;
      aux_boot_reg   <= aux_boot_sel;
      mgmt_address   <= strap_addr_sel ? `ADDR_B : `ADDR_A;
      core_ph_en_reg <= core_en_dec;
      aux_ph_en_reg  <= aux_en_dec;
      strap_bad_reg  <= core_gap | aux_gap;
    end
  end

  // Faults persist across supply dropouts; only reset or enable low clears them.
  always_ff @(posedge clock)
  begin
    if (srst)
      fault_latched <= 1'b0;
    else if (fault_event || (strap_bad_reg && state_reg != vr_startup_pkg::ST_OFF))
      fault_latched <= 1'b1;
    else if (!en_reg)
      fault_latched <= 1'b0;
  end

  wire aux_active  = aux_ph_en_reg[0];
  wire core_at     = core_target_vid == core_boot_reg;
  wire aux_at      = !aux_active || (aux_target_vid == aux_boot_reg);
  wire step_tick   = cnt_reg >= (`STEP_CYC - 32'd1);

  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg + 32'd1;
    core_vid_next = core_target_vid;
    aux_vid_next  = aux_target_vid;
    case (state_reg)
      vr_startup_pkg::ST_OFF:
      begin
        cnt_next = 32'd0;
        if (run_ok && !fault_latched)
          state_next = vr_startup_pkg::ST_DELAY;
      end
      vr_startup_pkg::ST_DELAY:
        if (cnt_reg >= (`START_DELAY_CYC - 32'd1))
        begin
          state_next = vr_startup_pkg::ST_RAMP;
          cnt_next   = 32'd0;
        end
      vr_startup_pkg::ST_RAMP:
        if (core_at && aux_at)
          state_next = vr_startup_pkg::ST_GOOD;
        else if (step_tick)
        begin
          cnt_next = 32'd0;
          // Codes fall as voltage rises, so each step decrements toward the boot code.
          if (!core_at)
            core_vid_next = core_target_vid - 8'h01;
          if (!aux_at)
            aux_vid_next = aux_target_vid - 8'h01;
        end
      vr_startup_pkg::ST_GOOD:
        cnt_next = 32'd0;
      default:
        state_next = vr_startup_pkg::ST_OFF;
    endcase
    if (!run_ok || fault_latched)
    begin
      state_next    = vr_startup_pkg::ST_OFF;
      core_vid_next = `VID_OFF;
      aux_vid_next  = `VID_OFF;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg       <= vr_startup_pkg::ST_OFF;
      cnt_reg         <= 32'd0;
      core_target_vid <= `VID_OFF;
      aux_target_vid  <= `VID_OFF;
    end
    else
    begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      core_target_vid <= core_vid_next;
      aux_target_vid  <= aux_vid_next;
    end
  end

  // Operating mode from the hints; one-phase modes keep only phase 1 driving.
  wire [1:0] mode_sel = low_power_hint0_n ? vr_startup_pkg::MODE_FULL_CCM :
                        low_power_hint1_n ? vr_startup_pkg::MODE_ONE_CCM :
                                            vr_startup_pkg::MODE_ONE_PSM;
  wire       full     = mode_sel == vr_startup_pkg::MODE_FULL_CCM;
  // Decoded from the next state so that a dropout or a fault removes the drives at the very next edge.
  wire       running  = (state_next == vr_startup_pkg::ST_RAMP) || (state_next == vr_startup_pkg::ST_GOOD);
  wire [3:0] core_use = running ? (full ? core_ph_en_reg : (core_ph_en_reg & 4'h1)) : 4'h0;
  wire [1:0] aux_use  = running ? (full ? aux_ph_en_reg : (aux_ph_en_reg & 2'h1)) : 2'h0;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      core_phase_drive <= 4'h0;
      core_drive_en    <= 4'h0;
      aux_phase_drive  <= 2'h0;
      aux_drive_en     <= 2'h0;
      rail_power_good  <= 1'b0;
      core_mode        <= vr_startup_pkg::MODE_FULL_CCM;
      aux_mode         <= vr_startup_pkg::MODE_FULL_CCM;
    end
    else
    begin
      core_phase_drive <= core_pulse_in & core_use;
      core_drive_en    <= core_use;
      aux_phase_drive  <= aux_pulse_in & aux_use;
      aux_drive_en     <= aux_use;
      rail_power_good  <= (state_next == vr_startup_pkg::ST_GOOD) && !fault_latched && !fault_event;
      core_mode        <= mode_sel;
      aux_mode         <= mode_sel;
    end
  end

  AST_OFF_ON_DROP: assert property (@(posedge clock) disable iff (srst)
    (!en_reg || !io_reg || !vin_reg) |=> (core_drive_en == 4'h0 && !rail_power_good))
    else $error("Rails not shut down after dropout.");
  AST_PG_AT_BOOT: assert property (@(posedge clock) disable iff (srst)
    rail_power_good |-> (core_target_vid == core_boot_reg && !fault_latched))
    else $error("Power-good without boot voltage.");
  AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (srst)
    (fault_latched && en_reg) |=> fault_latched)
    else $error("Fault cleared without enable toggle.");
  AST_FAULT_CLR: assert property (@(posedge clock) disable iff (srst)
    (!en_reg && !fault_event && !$past(en_reg)) |=> !fault_latched)
    else $error("Fault not cleared by enable low.");
  AST_DELAY: assert property (@(posedge clock) disable iff (srst)
    (state_reg == vr_startup_pkg::ST_OFF && state_next == vr_startup_pkg::ST_DELAY)
    |=> (state_reg != vr_startup_pkg::ST_RAMP) [*8])
    else $error("Ramp began before start delay.");
  AST_STRAP_FROZEN: assert property (@(posedge clock) disable iff (srst)
    strap_done_reg |=> $stable(core_boot_reg) && $stable(aux_boot_reg) && $stable(mgmt_address))
    else $error("Strap setting changed after capture.");
  AST_DIS_UNDRIVEN: assert property (@(posedge clock) disable iff (srst)
    ((core_phase_drive & ~core_drive_en) == 4'h0) && ((aux_phase_drive & ~aux_drive_en) == 2'h0))
    else $error("Disabled phase driven.");
  AST_MODE: assert property (@(posedge clock) disable iff (srst)
    (!low_power_hint0_n && !low_power_hint1_n) |=> (core_mode == vr_startup_pkg::MODE_ONE_PSM))
    else $error("Mode not one-phase saving.");
  AST_AUX_OFF: assert property (@(posedge clock) disable iff (srst)
    (strap_done_reg && $past(aux_total_sense_negative) && !$past(strap_done_reg)) |-> aux_ph_en_reg == 2'h0)
    else $error("Aux rail not disabled.");
endmodule

// >>> test/vr_phase_partner.sv
// Model of the external phase drivers that counts drive pulses seen on phases that are not enabled.
module vr_phase_partner (
  input  wire logic       clock,      // Bench clock
  input  wire logic [3:0] core_drive, // Core phase drives
  input  wire logic [3:0] core_en,    // Core drive enables
  input  wire logic [1:0] aux_drive,  // Aux phase drives
  input  wire logic [1:0] aux_en,     // Aux drive enables
  output int              bad_count   // Drives seen on disabled phases
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bad_count = 0;
  // A real power stage switches on any high input, so a stray pulse matters even when enable is low.
  always @(negedge clock)
  begin
    if (((core_drive & ~core_en) != 4'h0) || ((aux_drive & ~aux_en) != 2'h0))
    begin
      bad_count = bad_count + 1;
    end
  end
endmodule

// >>> test/tb_vr_startup_and_phase_config.sv
// Self-checking bench for the start-up sequencer, strap capture and phase configuration.
module tb_vr_startup_and_phase_config;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {time due; logic [7:0] val;} note_s;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       io_reference_supply = 1'b0;
  logic       input_voltage_sense = 1'b0;
  logic       chip_enable = 1'b0;
  logic       vid_bus_clock = 1'b1;
  logic       vid_bus_data = 1'b1;
  logic [1:0] strap_setting_input = 2'h3;
  logic       strap_addr_sel = 1'b1;
  logic [3:0] phase_sense_negative = 4'h8;
  logic [1:0] aux_phase_sense_negative = 2'h2;
  logic       aux_total_sense_negative = 1'b0;
  logic       low_power_hint0_n = 1'b1;
  logic       low_power_hint1_n = 1'b1;
  logic [3:0] core_pulse_in = 4'h0;
  logic [1:0] aux_pulse_in = 2'h0;
  logic       fault_event = 1'b0;
  logic [3:0] core_phase_drive, core_drive_en;
  logic [1:0] aux_phase_drive, aux_drive_en, core_mode, aux_mode;
  logic [7:0] core_target_vid, aux_target_vid, mgmt_address;
  logic       rail_power_good, fault_latched;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         bad_count, n;
  logic [31:0] seed = 32'h0D0D;
  note_s      exp_q[$];

  vr_startup_and_phase_config dut_u (.clock(clock), .srst(srst), .io_reference_supply(io_reference_supply),
    .input_voltage_sense(input_voltage_sense), .chip_enable(chip_enable), .vid_bus_clock(vid_bus_clock),
    .vid_bus_data(vid_bus_data), .strap_setting_input(strap_setting_input), .strap_addr_sel(strap_addr_sel),
    .phase_sense_negative(phase_sense_negative), .aux_phase_sense_negative(aux_phase_sense_negative),
    .aux_total_sense_negative(aux_total_sense_negative), .low_power_hint0_n(low_power_hint0_n),
    .low_power_hint1_n(low_power_hint1_n), .core_pulse_in(core_pulse_in), .aux_pulse_in(aux_pulse_in),
    .fault_event(fault_event), .core_phase_drive(core_phase_drive), .core_drive_en(core_drive_en),
    .aux_phase_drive(aux_phase_drive), .aux_drive_en(aux_drive_en), .core_target_vid(core_target_vid),
    .aux_target_vid(aux_target_vid), .mgmt_address(mgmt_address), .rail_power_good(rail_power_good),
    .fault_latched(fault_latched), .core_mode(core_mode), .aux_mode(aux_mode));

  vr_phase_partner partner_u (.clock(clock), .core_drive(core_phase_drive), .core_en(core_drive_en),
    .aux_drive(aux_phase_drive), .aux_en(aux_drive_en), .bad_count(bad_count));

  initial
  begin
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(negedge clock)
  begin
    if (exp_q.size() > 0 && exp_q[0].due < $time)
    begin
      chk({10'h000, aux_phase_drive, core_phase_drive}, {8'h00, exp_q[0].val});
      void'(exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (80000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    // Strap pins move after capture; the captured settings must not follow them.
    vid_bus_clock <= 1'b0;
    strap_setting_input <= 2'h0;
    strap_addr_sel <= 1'b0;
    phase_sense_negative <= 4'h0;
    io_reference_supply <= 1'b1;
    input_voltage_sense <= 1'b1;
    repeat (10) @(posedge clock);
    #1;
    chk(16'(mgmt_address), 16'h008A);
    chk(16'(rail_power_good), 16'h0000);
    @(posedge clock);
    chip_enable <= 1'b1;
    repeat (49990) @(posedge clock);
    #1;
    chk({core_target_vid, 4'h0, core_drive_en}, 16'hF800);
    repeat (110) @(posedge clock);
    #1;
    chk({4'h0, core_drive_en, 6'h00, aux_drive_en}, 16'h0701);
    chk(16'(core_target_vid < 8'hF8 && core_target_vid > 8'hF0), 16'h0001);
    n = 50100;
    while (rail_power_good !== 1'b1 && n < 58000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(16'(n >= 56655 && n <= 56675), 16'h0001);
    chk({core_target_vid, aux_target_vid}, 16'h7878);
    chk({7'h00, fault_latched, 2'b00, core_mode, 2'b00, aux_mode}, 16'h0000);
    repeat (200)
    begin
      @(posedge clock);
      seed = xs(seed);
      core_pulse_in <= seed[3:0];
      aux_pulse_in <= seed[5:4];
      exp_q.push_back('{$time + 10, {2'b00, seed[5:4] & 2'b01, seed[3:0] & 4'b0111}});
    end
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge clock);
      {low_power_hint0_n, low_power_hint1_n} <= 2'(i);
      repeat (3) @(posedge clock);
      #1;
      chk({6'h00, core_mode, 6'h00, aux_mode}, i > 1 ? 16'h0000 : (i == 1 ? 16'h0101 : 16'h0202));
    end
    @(posedge clock);
    io_reference_supply <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk({core_target_vid, 3'h0, rail_power_good, core_drive_en}, 16'hF800);
    @(posedge clock);
    io_reference_supply <= 1'b1;
    repeat (10) @(posedge clock);
    fault_event <= 1'b1;
    @(posedge clock);
    fault_event <= 1'b0;
    repeat (3) @(posedge clock);
    input_voltage_sense <= 1'b0;
    repeat (10) @(posedge clock);
    input_voltage_sense <= 1'b1;
    repeat (10) @(posedge clock);
    #1;
    chk({15'h0000, fault_latched}, 16'h0001);
    @(posedge clock);
    chip_enable <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk({15'h0000, fault_latched}, 16'h0000);
    @(posedge clock);
    srst <= 1'b1;
    // A gap in the core phases is an unsupported strap and must fault as soon as a start is tried.
    phase_sense_negative <= 4'h4;
    aux_total_sense_negative <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk(16'(mgmt_address), 16'h0088);
    @(posedge clock);
    chip_enable <= 1'b1;
    repeat (8) @(posedge clock);
    #1;
    chk({14'h0000, fault_latched, rail_power_good}, 16'h0002);
    chk(16'(bad_count), 16'h0000);
    end_sim();
  end
endmodule
